// ---- hw/dcr_pkg.sv ----
// Constants for the debug command register decoder behind the debug TAP.
// Assumes a single 125 MHz system clock that oversamples the test clock.
package dcr_pkg;

  // ---------------------------------------------------------------
  // Command register layout
  // ---------------------------------------------------------------
  localparam int unsigned CMD_W      = 10;
  localparam int unsigned RW_BIT     = 0;
  localparam int unsigned GO_BIT     = 1;
  localparam int unsigned EXIT_BIT   = 2;
  localparam int unsigned SEL_LSB    = 3;
  localparam int unsigned SEL_MSB    = 9;
  localparam int unsigned SEL_W      = 7;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned EDM_BIT    = 31;

  localparam logic [CMD_W-1:0] CMD_RST    = 10'h011 << 3;
  localparam logic [CMD_W-1:0] STAT_FIXED = 10'h001;
  localparam int unsigned      STAT_DBG   = 3;

  // ---------------------------------------------------------------
  // Select codes
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_ID_REG     = 7'h02;
  localparam logic [SEL_W-1:0] SEL_CPU_SCAN   = 7'h10;
  localparam logic [SEL_W-1:0] SEL_NONE       = 7'h11;
  localparam logic [SEL_W-1:0] SEL_DBG_CTRL   = 7'h12;
  localparam logic [SEL_W-1:0] SEL_CMP_FIRST  = 7'h20;
  localparam logic [SEL_W-1:0] SEL_CMP_LAST   = 7'h2b;
  localparam logic [SEL_W-1:0] SEL_DBG_CNT    = 7'h2c;
  localparam logic [SEL_W-1:0] SEL_PC_HIST    = 7'h2d;
  localparam logic [SEL_W-1:0] SEL_EXT_CTRL   = 7'h2e;
  localparam logic [SEL_W-1:0] SEL_EXT_STAT   = 7'h2f;
  localparam logic [SEL_W-1:0] SEL_DBG_STAT   = 7'h30;
  localparam logic [SEL_W-1:0] SEL_CTRL_ZERO  = 7'h31;
  localparam logic [SEL_W-1:0] SEL_CTRL_LAST  = 7'h37;
  localparam logic [SEL_W-1:0] SEL_BAD_FIRST  = 7'h38;
  localparam logic [SEL_W-1:0] SEL_BAD_LAST   = 7'h3c;
  localparam logic [SEL_W-1:0] SEL_ACQ_MSG    = 7'h3d;
  localparam logic [SEL_W-1:0] SEL_EVT_CTRL   = 7'h3e;
  localparam logic [SEL_W-1:0] SEL_EXT_RES    = 7'h3f;
  localparam logic [SEL_W-1:0] SEL_GPR_FIRST  = 7'h70;
  localparam logic [SEL_W-1:0] SEL_GPR_LAST   = 7'h79;
  localparam logic [SEL_W-1:0] SEL_CACHE_CTRL = 7'h7a;
  localparam logic [SEL_W-1:0] SEL_CACHE_DATA = 7'h7b;

  // Arbitrary neutral identification value
  localparam logic [DATA_W-1:0] ID_CODE_DEF = 32'h0000_0001;

  typedef enum logic [1:0] {
    CLS_INVALID,
    CLS_BYPASS,
    CLS_RW,
    CLS_RO
  } dcr_class_type;

  typedef enum logic [3:0] {
    TST_RESET, TST_IDLE,
    TST_SEL_DR, TST_CAP_DR, TST_SHIFT_DR, TST_EXIT1_DR, TST_PAUSE_DR, TST_EXIT2_DR, TST_UPD_DR,
    TST_SEL_IR, TST_CAP_IR, TST_SHIFT_IR, TST_EXIT1_IR, TST_PAUSE_IR, TST_EXIT2_IR, TST_UPD_IR
  } dcr_tap_type;

endpackage : dcr_pkg

// ---- hw/dcr_pin_sync.sv ----
// Two-flop synchroniser for the test pins, with edge detect on the clock pin.
// Assumes pins are asynchronous to clk_i and the test clock is far slower.
`timescale 1ns/1ns
`default_nettype none
module dcr_pin_sync
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      rise_o,
  output logic      fall_o
);

  // Idle pin levels {tck, tms, tdi}: clock and mode select high, so no false edge after reset
  localparam logic [2:0] PIN_IDLE = 3'h6;

  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic       tck_prev_ff;

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_ff     <= PIN_IDLE;
      sync_ff     <= PIN_IDLE;
      tck_prev_ff <= PIN_IDLE[2];
    end
    else
    begin
      meta_ff     <= {tck_i, tms_i, tdi_i};
      sync_ff     <= meta_ff;
      tck_prev_ff <= sync_ff[2];
    end
  end

  assign tms_o  = sync_ff[1];
  assign tdi_o  = sync_ff[0];
  assign rise_o = sync_ff[2] & ~tck_prev_ff;
  assign fall_o = ~sync_ff[2] & tck_prev_ff;

endmodule : dcr_pin_sync
`default_nettype wire

// ---- hw/dcr_decode.sv ----
// Debug TAP: command register, select decode, data scan and run control.
// Assumes the core presents read data for rd_sel_o on rd_data_i at all times.
//
// Contract
// - Honoured exit bit leaves debug mode; clear exit bit keeps it.
// - Exit only honoured with go set and cpu scan or no-register selected.
// - Honoured go/exit takes effect on entry to Update-DR.
// - Debug request or status bit with external debug keeps core halted.
// - Select field bits 3..9 pick the resource for the next data scan.
// - Write scans to read-only resources change nothing.
// - Before external debug enable, only that bit of control zero is accessible.
// - External debug enable turns on external debug, locks software out.
// - Codes 10h cpu scan, 11h none, 12h control, 02h read-only id.
// - Codes 00-01, 03-0F, 13-1F, 38-3C are invalid.
// - Codes 20-2B select instruction, data address and data value compares.
// - 2C counter, 2D read-only pc history, 2E/2F external control/status.
// - 30 debug status, 31-37 debug control zero to six.
// - 3D acquisition message, 3E event control, 3F external resource.
// - 70-79 general purpose register selects zero to nine.
// - 7A cache access control, 7B cache access data.
// - Ten-bit command shifts from test input, loads on Update-IR.
// - Bit 0 picks write or read; ignored for read-only and bypass.
// - Go bit executes the cpu scan chain instruction.
`timescale 1ns/1ns
`default_nettype none
module dcr_decode
#(
  parameter logic [dcr_pkg::DATA_W-1:0] ID_CODE = dcr_pkg::ID_CODE_DEF
)
(
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       tck_i,
  input  wire logic                       tms_i,
  input  wire logic                       tdi_i,
  input  wire logic                       dbg_request_i,
  input  wire logic                       dbg_status_any_i,
  input  wire logic [dcr_pkg::DATA_W-1:0] rd_data_i,
  output logic                            tdo_o,
  output logic                            tdo_oe_o,
  output logic [dcr_pkg::SEL_W-1:0]       rd_sel_o,
  output logic                            wr_stb_o,
  output logic [dcr_pkg::SEL_W-1:0]       wr_sel_o,
  output logic [dcr_pkg::DATA_W-1:0]      wr_data_o,
  output logic                            exec_o,
  output logic                            debug_mode_o,
  output logic                            ext_debug_enable_o,
  output logic                            sw_lock_o
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic dcr_pkg::dcr_class_type sel_class(input logic [dcr_pkg::SEL_W-1:0] s);
    if (s == dcr_pkg::SEL_ID_REG || s == dcr_pkg::SEL_PC_HIST)
      sel_class = dcr_pkg::CLS_RO;
    else if (s == dcr_pkg::SEL_NONE)
      sel_class = dcr_pkg::CLS_BYPASS;
    else if (s == dcr_pkg::SEL_CPU_SCAN || s == dcr_pkg::SEL_DBG_CTRL)
      sel_class = dcr_pkg::CLS_RW;
    else if (s >= dcr_pkg::SEL_CMP_FIRST && s <= dcr_pkg::SEL_CTRL_LAST)
      sel_class = dcr_pkg::CLS_RW;
    else if (s >= dcr_pkg::SEL_ACQ_MSG && s <= dcr_pkg::SEL_EXT_RES)
      sel_class = dcr_pkg::CLS_RW;
    else if (s >= dcr_pkg::SEL_GPR_FIRST && s <= dcr_pkg::SEL_CACHE_DATA)
      sel_class = dcr_pkg::CLS_RW;
    else
      sel_class = dcr_pkg::CLS_INVALID;
  endfunction : sel_class

  function automatic dcr_pkg::dcr_tap_type tap_next(input dcr_pkg::dcr_tap_type s,
                                                   input logic m);
    unique case (s)
      dcr_pkg::TST_RESET:    tap_next = m ? dcr_pkg::TST_RESET   : dcr_pkg::TST_IDLE;
      dcr_pkg::TST_IDLE:     tap_next = m ? dcr_pkg::TST_SEL_DR  : dcr_pkg::TST_IDLE;
      dcr_pkg::TST_SEL_DR:   tap_next = m ? dcr_pkg::TST_SEL_IR  : dcr_pkg::TST_CAP_DR;
      dcr_pkg::TST_CAP_DR:   tap_next = m ? dcr_pkg::TST_EXIT1_DR : dcr_pkg::TST_SHIFT_DR;
      dcr_pkg::TST_SHIFT_DR: tap_next = m ? dcr_pkg::TST_EXIT1_DR : dcr_pkg::TST_SHIFT_DR;
      dcr_pkg::TST_EXIT1_DR: tap_next = m ? dcr_pkg::TST_UPD_DR  : dcr_pkg::TST_PAUSE_DR;
      dcr_pkg::TST_PAUSE_DR: tap_next = m ? dcr_pkg::TST_EXIT2_DR : dcr_pkg::TST_PAUSE_DR;
      dcr_pkg::TST_EXIT2_DR: tap_next = m ? dcr_pkg::TST_UPD_DR  : dcr_pkg::TST_SHIFT_DR;
      dcr_pkg::TST_UPD_DR:   tap_next = m ? dcr_pkg::TST_SEL_DR  : dcr_pkg::TST_IDLE;
      dcr_pkg::TST_SEL_IR:   tap_next = m ? dcr_pkg::TST_RESET   : dcr_pkg::TST_CAP_IR;
      dcr_pkg::TST_CAP_IR:   tap_next = m ? dcr_pkg::TST_EXIT1_IR : dcr_pkg::TST_SHIFT_IR;
      dcr_pkg::TST_SHIFT_IR: tap_next = m ? dcr_pkg::TST_EXIT1_IR : dcr_pkg::TST_SHIFT_IR;
      dcr_pkg::TST_EXIT1_IR: tap_next = m ? dcr_pkg::TST_UPD_IR  : dcr_pkg::TST_PAUSE_IR;
      dcr_pkg::TST_PAUSE_IR: tap_next = m ? dcr_pkg::TST_EXIT2_IR : dcr_pkg::TST_PAUSE_IR;
      dcr_pkg::TST_EXIT2_IR: tap_next = m ? dcr_pkg::TST_UPD_IR  : dcr_pkg::TST_SHIFT_IR;
      dcr_pkg::TST_UPD_IR:   tap_next = m ? dcr_pkg::TST_SEL_DR  : dcr_pkg::TST_IDLE;
    endcase
  endfunction : tap_next

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                       tms_s;
  logic                       tdi_s;
  logic                       tck_rise;
  logic                       tck_fall;
  dcr_pkg::dcr_tap_type       tap_ff;
  dcr_pkg::dcr_tap_type       nxt_tap;
  logic [dcr_pkg::CMD_W-1:0]  ir_ff;
  logic [dcr_pkg::CMD_W-1:0]  cmd_ff;
  logic [dcr_pkg::DATA_W-1:0] dr_ff;
  logic                       edm_ff;
  logic                       dbg_mode_ff;
  logic [dcr_pkg::SEL_W-1:0]  cur_sel;
  dcr_pkg::dcr_class_type     cur_cls;
  logic                       is_write;
  logic                       go_target;
  logic                       honour_exit;
  logic                       halt_cause;
  logic                       cap_ir_evt;
  logic                       upd_ir_evt;
  logic                       cap_dr_evt;
  logic                       upd_dr_evt;
  logic                       wide_dr;
  logic [dcr_pkg::DATA_W-1:0] cap_val;
  logic [dcr_pkg::DATA_W-1:0] edm_only;

  dcr_pin_sync u_pin_sync
  (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tck_i  (tck_i),
    .tms_i  (tms_i),
    .tdi_i  (tdi_i),
    .tms_o  (tms_s),
    .tdi_o  (tdi_s),
    .rise_o (tck_rise),
    .fall_o (tck_fall)
  );

  assign nxt_tap     = tap_next(tap_ff, tms_s);
  assign cur_sel     = cmd_ff[dcr_pkg::SEL_MSB:dcr_pkg::SEL_LSB];
  assign cur_cls     = sel_class(cur_sel);
  assign is_write    = ~cmd_ff[dcr_pkg::RW_BIT] && cur_cls == dcr_pkg::CLS_RW;
  assign go_target   = cur_sel == dcr_pkg::SEL_CPU_SCAN || cur_sel == dcr_pkg::SEL_NONE;
  assign honour_exit = cmd_ff[dcr_pkg::GO_BIT] && cmd_ff[dcr_pkg::EXIT_BIT] && go_target;
  assign halt_cause  = dbg_request_i || (dbg_status_any_i && edm_ff);
  assign wide_dr     = cur_cls == dcr_pkg::CLS_RW || cur_cls == dcr_pkg::CLS_RO;
  assign cap_ir_evt  = tck_rise && nxt_tap == dcr_pkg::TST_CAP_IR;
  assign upd_ir_evt  = tck_rise && nxt_tap == dcr_pkg::TST_UPD_IR;
  assign cap_dr_evt  = tck_rise && nxt_tap == dcr_pkg::TST_CAP_DR;
  assign upd_dr_evt  = tck_rise && nxt_tap == dcr_pkg::TST_UPD_DR;
  assign edm_only    = {edm_ff, {(dcr_pkg::DATA_W-1){1'b0}}};

  always_comb
  begin
    if (cur_sel == dcr_pkg::SEL_ID_REG)
      cap_val = ID_CODE;
    else if (cur_sel == dcr_pkg::SEL_CTRL_ZERO && !edm_ff)
      cap_val = edm_only;
    else if (cur_sel == dcr_pkg::SEL_CTRL_ZERO)
    begin
      cap_val = rd_data_i;
      cap_val[dcr_pkg::EDM_BIT] = edm_ff;
    end
    else if (wide_dr)
      cap_val = rd_data_i;
    else
      cap_val = '0;
  end

  // ---------------------------------------------------------------
  // TAP state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      tap_ff <= dcr_pkg::TST_RESET;
    else if (tck_rise)
      tap_ff <= nxt_tap;
  end

  // ---------------------------------------------------------------
  // Command register scan
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ir_ff <= '0;
    else if (cap_ir_evt)
    begin
      ir_ff <= dcr_pkg::STAT_FIXED;
      ir_ff[dcr_pkg::STAT_DBG] <= dbg_mode_ff;
    end
    else if (tck_rise && tap_ff == dcr_pkg::TST_SHIFT_IR)
      ir_ff <= {tdi_s, ir_ff[dcr_pkg::CMD_W-1:1]};
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || (tck_rise && tap_ff == dcr_pkg::TST_RESET))
      cmd_ff <= dcr_pkg::CMD_RST;
    else if (upd_ir_evt)
      cmd_ff <= ir_ff;
  end

  // ---------------------------------------------------------------
  // Data scan
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      dr_ff <= '0;
    else if (cap_dr_evt)
      dr_ff <= cap_val;
    else if (tck_rise && tap_ff == dcr_pkg::TST_SHIFT_DR)
    begin
      if (wide_dr)
        dr_ff <= {tdi_s, dr_ff[dcr_pkg::DATA_W-1:1]};
      else
        dr_ff[0] <= tdi_s;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_o    <= (tap_ff == dcr_pkg::TST_SHIFT_IR) ? ir_ff[0] : dr_ff[0];
      tdo_oe_o <= tap_ff == dcr_pkg::TST_SHIFT_IR || tap_ff == dcr_pkg::TST_SHIFT_DR;
    end
  end

  // ---------------------------------------------------------------
  // Resource write port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_stb_o  <= 1'b0;
      wr_sel_o  <= '0;
      wr_data_o <= '0;
      rd_sel_o  <= '0;
    end
    else
    begin
      rd_sel_o <= cur_sel;
      wr_stb_o <= upd_dr_evt && is_write;
      if (upd_dr_evt && is_write)
      begin
        wr_sel_o <= cur_sel;
        if (cur_sel == dcr_pkg::SEL_CTRL_ZERO && !edm_ff)
          wr_data_o <= {dr_ff[dcr_pkg::EDM_BIT], {(dcr_pkg::DATA_W-1){1'b0}}};
        else
          wr_data_o <= dr_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // External debug enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      edm_ff <= 1'b0;
    else if (upd_dr_evt && is_write && cur_sel == dcr_pkg::SEL_CTRL_ZERO)
      edm_ff <= dr_ff[dcr_pkg::EDM_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ext_debug_enable_o <= 1'b0;
      sw_lock_o          <= 1'b0;
    end
    else
    begin
      ext_debug_enable_o <= edm_ff;
      sw_lock_o          <= edm_ff;
    end
  end

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      exec_o <= 1'b0;
    else
      exec_o <= upd_dr_evt && cmd_ff[dcr_pkg::GO_BIT] && go_target;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      dbg_mode_ff <= 1'b0;
    else if (halt_cause)
      dbg_mode_ff <= 1'b1;
    else if (upd_dr_evt && honour_exit)
      dbg_mode_ff <= 1'b0;
  end

  assign debug_mode_o = dbg_mode_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_exit_cause: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(dbg_mode_ff) |-> $past(upd_dr_evt && honour_exit))
    else $error("debug mode left without honoured exit");

  a_exit_gated: assert property (@(posedge clk_i) disable iff (srst_i)
    (upd_dr_evt && dbg_mode_ff && !halt_cause && !honour_exit) |=> dbg_mode_ff)
    else $error("exit taken without go or on wrong target");

  a_stay_halted: assert property (@(posedge clk_i) disable iff (srst_i)
    (upd_dr_evt && honour_exit && halt_cause) |=> dbg_mode_ff)
    else $error("core left debug mode despite halt cause");

  a_write_target: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb_o |-> $past(upd_dr_evt) && sel_class(wr_sel_o) == dcr_pkg::CLS_RW)
    else $error("write to read-only or invalid resource");

  a_write_select: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb_o |-> wr_sel_o == $past(cur_sel) && !$past(cmd_ff[dcr_pkg::RW_BIT]))
    else $error("write went to wrong resource or on read");

  a_edm_mask: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_stb_o && wr_sel_o == dcr_pkg::SEL_CTRL_ZERO && !$past(edm_ff))
      |-> wr_data_o[dcr_pkg::EDM_BIT-1:0] == '0)
    else $error("control zero bits written before enable");

  a_lock_follow: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(edm_ff) |=> sw_lock_o && ext_debug_enable_o)
    else $error("software lock not applied");

  a_cmd_load: assert property (@(posedge clk_i) disable iff (srst_i)
    upd_ir_evt |=> cmd_ff == $past(ir_ff))
    else $error("command register not loaded at update");

  a_go_exec: assert property (@(posedge clk_i) disable iff (srst_i)
    (upd_dr_evt && cmd_ff[dcr_pkg::GO_BIT] && go_target) |=> exec_o ##1 !exec_o)
    else $error("go did not give one execute pulse");

  a_invalid_idle: assert property (@(posedge clk_i) disable iff (srst_i)
    (upd_dr_evt && cur_cls == dcr_pkg::CLS_INVALID) |=> !wr_stb_o && $stable(edm_ff))
    else $error("invalid code changed a resource");

endmodule : dcr_decode
`default_nettype wire

// ---- test/dcr_probe.sv ----
// Behavioural debug probe that drives the test pins and runs IR and DR scans.
// Assumes clk_i is the 8 ns system clock; the test clock is built from it at 80 ns.
`timescale 1ns/1ns
`default_nettype none
module dcr_probe
(
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  // Test clock stands high between frames
  initial
  begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One test clock: 6 clk low, 4 clk high; tdo is taken just before the rise
  task automatic tick(input logic ms, input logic di, output logic do_bit);
    @(posedge clk_i);
    tck_o <= 1'b0;
    tms_o <= ms;
    tdi_o <= di;
    repeat (6) @(posedge clk_i);
    do_bit = tdo_i & tdo_oe_i;
    tck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : tick

  // Five ticks with mode select high, then one low to park in Idle
  task automatic to_idle();
    logic unused;
    repeat (5) tick(1'b1, ~tdi_o, unused);
    tick(1'b0, ~tdi_o, unused);
  endtask : to_idle

  // Idle to scan, shift n bits, Update, back to Idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic unused;
    dout = '0;
    tick(1'b1, ~tdi_o, unused);
    if (is_ir)
      tick(1'b1, ~tdi_o, unused);
    tick(1'b0, ~tdi_o, unused);
    tick(1'b0, ~tdi_o, unused);
    for (int i = 0; i < n; i++)
      tick(i == n - 1, din[i], dout[i]);
    tick(1'b1, ~tdi_o, unused);
    tick(1'b0, ~tdi_o, unused);
  endtask : scan
endmodule : dcr_probe
`default_nettype wire

// ---- test/test_debug_command_register_decode.sv ----
// Self-checking bench for the debug command register decoder.
// Assumes the probe model in dcr_probe.sv and the design under hw/.
`timescale 1ns/1ns
`default_nettype none
module test_debug_command_register_decode;
  localparam logic [31:0] ID_VAL = 32'h0c3a_5e71; // Arbitrary identification value
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        tck, tms, tdi, tdo, tdo_oe;
  logic        dbg_request = 1'b0;
  logic        dbg_status_any = 1'b0;
  logic [31:0] rd_data = 32'h0000_1234;
  logic [6:0]  rd_sel, wr_sel;
  logic [31:0] wr_data, q;
  logic [9:0]  status;
  logic        wr_stb, exec_pulse, debug_mode, ext_en, sw_lock;
  int          error_cnt = 0;
  int          compares = 0;
  int          stb_cnt = 0;
  int          exec_cnt = 0;
  int          s0;

  always #4 clk_i = ~clk_i;

  dcr_decode #(.ID_CODE(ID_VAL)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .dbg_request_i(dbg_request), .dbg_status_any_i(dbg_status_any),
    .rd_data_i(rd_data), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .rd_sel_o(rd_sel), .wr_stb_o(wr_stb),
    .wr_sel_o(wr_sel), .wr_data_o(wr_data), .exec_o(exec_pulse), .debug_mode_o(debug_mode),
    .ext_debug_enable_o(ext_en), .sw_lock_o(sw_lock));

  dcr_probe probe_u (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi));

  always @(posedge clk_i)
  begin
    if (wr_stb === 1'b1)
      stb_cnt <= stb_cnt + 1;
    if (exec_pulse === 1'b1)
      exec_cnt <= exec_cnt + 1;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic access(input logic [9:0] cmd, input logic [31:0] din);
    logic [31:0] st;
    probe_u.scan(1'b1, 10, {22'h0, cmd}, st);
    status = st[9:0];
    probe_u.scan(1'b0, 32, din, q);
    repeat (12) @(posedge clk_i);
  endtask : access

  task automatic halt();
    @(posedge clk_i);
    dbg_request <= 1'b1;
    repeat (3) @(posedge clk_i);
    dbg_request <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : halt

  function automatic bit writable(input logic [6:0] c);
    return c == 7'h10 || c == 7'h12 || (c >= 7'h20 && c <= 7'h37 && c != 7'h2d)
      || (c >= 7'h3d && c <= 7'h3f) || (c >= 7'h70 && c <= 7'h7b);
  endfunction : writable

  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({31'h0, debug_mode}, 32'h0, "debug mode after reset");
    probe_u.to_idle();
    probe_u.scan(1'b0, 8, 32'h0000_00b5, q);
    check(q, 32'h0000_006a, "reset command bypass");
    check({25'h0, rd_sel}, 32'h0000_0011, "reset select");
    halt();
    check({31'h0, debug_mode}, 32'h1, "halt by request");
    access({7'h02, 3'b001}, 32'hffff_ffff);
    check(q, ID_VAL, "identification read");
    check({22'h0, status}, 32'h0000_0009, "capture status");
    check({25'h0, rd_sel}, 32'h0000_0002, "select follows command");
    s0 = stb_cnt;
    access({7'h02, 3'b000}, 32'h5555_aaaa);
    access({7'h12, 3'b001}, 32'h5555_aaaa);
    check(32'(stb_cnt), 32'(s0), "no strobe for read or read-only");
    access({7'h31, 3'b000}, 32'h7fff_ffff);
    check(32'(stb_cnt), 32'(s0 + 1), "control zero strobe");
    check(wr_data, 32'h0, "locked bits masked");
    check({31'h0, ext_en}, 32'h0, "enable still clear");
    access({7'h31, 3'b001}, 32'h0);
    check(q, 32'h0, "only enable bit visible");
    access({7'h31, 3'b000}, 32'h8000_00a5);
    check(wr_data, 32'h8000_0000, "enable write masked");
    check({30'h0, ext_en, sw_lock}, 32'h3, "external debug and lock");
    access({7'h31, 3'b001}, 32'h0);
    check(q, 32'h8000_1234, "control zero readback");
    for (int c = 0; c < 128; c++)
    begin
      if ((c > 8'h40 && c < 8'h6f) || (c >= 8'h38 && c <= 8'h3c))
        continue;
      s0 = stb_cnt;
      access({c[6:0], 3'b000}, 32'h8000_5a00 | c);
      if (writable(c[6:0]))
      begin
        check(32'(stb_cnt), 32'(s0 + 1), "strobe count");
        check({25'h0, wr_sel}, 32'(c), "write select");
        check(wr_data, 32'h8000_5a00 | c, "write data");
      end
      else
      begin
        check(32'(stb_cnt), 32'(s0), "no strobe");
        if (c == 8'h2d)
          check(q, rd_data, "history buffer read");
        else if (c != 8'h02)
          check(q, (32'h8000_5a00 | c) << 1, "bypass path");
      end
    end
    halt();
    s0 = exec_cnt;
    access({7'h10, 3'b100}, 32'h0);
    access({7'h12, 3'b110}, 32'h0);
    check({31'h0, debug_mode}, 32'h1, "exit ignored");
    check(32'(exec_cnt), 32'(s0), "no execute");
    access({7'h11, 3'b010}, 32'h0);
    check({31'h0, debug_mode}, 32'h1, "go without exit stays");
    check(32'(exec_cnt), 32'(s0 + 1), "go executes");
    dbg_status_any <= 1'b1;
    access({7'h10, 3'b110}, 32'h0);
    check({31'h0, debug_mode}, 32'h1, "status holds debug");
    dbg_status_any <= 1'b0;
    access({7'h10, 3'b110}, 32'h0);
    check({31'h0, debug_mode}, 32'h0, "exit honoured");
    check(32'(exec_cnt), 32'(s0 + 3), "go count");
    // Second reset in mid-run: command back to no register, enable cleared
    srst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({23'h0, rd_sel, ext_en, debug_mode}, 32'h0000_0044, "state after second reset");
    probe_u.to_idle();
    access({7'h11, 3'b001}, 32'h0);
    check({22'h0, status}, 32'h0000_0001, "status after second reset");
    complete_run();
  end

  initial
  begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : test_debug_command_register_decode
`default_nettype wire
